// ---- design/dtp_params.svh ----
// Constants for the dual timer with pulse and PWM modes: field codes,
// reset values and compare limits.
// Assumes inclusion by bare name from the design files only.
`ifndef DTP_PARAMS_SVH
`define DTP_PARAMS_SVH

`define DTP_CNT_W            8
`define DTP_MODE_INTERVAL    2'h0
`define DTP_MODE_CASCADE     2'h1
`define DTP_MODE_PPG         2'h2
`define DTP_MODE_PWM         2'h3

`define DTP_PWM_SEL_6        2'h1
`define DTP_PWM_SEL_7        2'h2
`define DTP_PWM_SEL_8        2'h3
`define DTP_PWM_OVF_6        8'h3F
`define DTP_PWM_OVF_7        8'h7F
`define DTP_PWM_OVF_8        8'hFF

`define DTP_LCLK_EXT         2'h0
`define DTP_LCLK_T1          2'h1
`define DTP_LCLK_T4          2'h2
`define DTP_LCLK_T16         2'h3
`define DTP_UCLK_MATCH       2'h0
`define DTP_UCLK_T1          2'h1
`define DTP_UCLK_T16         2'h2
`define DTP_UCLK_T256        2'h3

`define DTP_FFC_TOGGLE       2'h0
`define DTP_FFC_SET          2'h1
`define DTP_FFC_CLEAR        2'h2
`define DTP_FFC_NONE         2'h3
`define DTP_FFC_READBACK     2'h3

`define DTP_RST_REG          8'h00
`define DTP_RST_FF           1'b0

`endif

// ---- design/dtp_pkg.sv ----
// Types shared by the dual timer design.
// Assumes dtp_params.svh is on the include path.
`include "dtp_params.svh"

package dtp_pkg;

	typedef enum logic [1:0] {
		DTP_INTERVAL,
		DTP_CASCADE,
		DTP_PPG,
		DTP_PWM
	} dtp_mode_t;

	function automatic dtp_mode_t dtp_decode_mode(input logic [1:0] field);
		dtp_mode_t m;
		m = DTP_INTERVAL;
		case (field)
			`DTP_MODE_INTERVAL: m = DTP_INTERVAL;
			`DTP_MODE_CASCADE:  m = DTP_CASCADE;
			`DTP_MODE_PPG:      m = DTP_PPG;
			`DTP_MODE_PWM:      m = DTP_PWM;
			default:            m = DTP_INTERVAL;
		endcase
		return m;
	endfunction : dtp_decode_mode

endpackage : dtp_pkg

// ---- design/dtp_counter.sv ----
// One up-counter of the timer pair: clears while stopped, steps on tick,
// returns to zero when wrap is asserted with the tick.
// Assumes tick and wrap are single-cycle enables on clk_sys.
`timescale 1ns/1ps

module dtp_counter #(
	parameter int W = 8
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	input  wire logic         run,
	input  wire logic         tick,
	input  wire logic         wrap,
	output logic      [W-1:0] count
);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else if (!run) begin
			count <= '0;
		end else if (tick) begin
			if (wrap) begin
				count <= '0;
			end else begin
				count <= count + 1'b1;
			end
		end
	end

endmodule : dtp_counter

// ---- design/dtp_top.sv ----
// Timer pair with programmable pulse and PWM output on one flip-flop.
// Assumes prescaler taps are one-cycle enables on clk_sys and that the
// external lower-timer clock is an asynchronous pin.
`timescale 1ns/1ps
`include "dtp_params.svh"

// Contract
// - Pulse mode toggles on duty and period matches
// - Preloaded flip-flop state sets pulse polarity
// - Pulse mode uses lower timer, upper pin
// - Buffered duty loads on period match
// - PWM: upper is interval timer, no pin
// - PWM toggles on duty match and overflow
// - PWM exponent selectable as 6, 7, 8
// - PWM counter returns to zero on overflow
// - Buffered duty loads on PWM overflow
// - Mode field 10 pulse, 11 PWM
// - Period field 10 selects 127 counts
// - Control 10 clears, 01 sets flip-flop
// - Clearing run bit stops, clears counter
// - Control 00 toggles, 11 none, reads 11
module dtp_top
	import dtp_pkg::*;
#(
	parameter int CNT_W = `DTP_CNT_W
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic [1:0]       mode_field,
	input  wire logic [1:0]       pwm_period_sel,
	input  wire logic [1:0]       lower_clk_sel,
	input  wire logic [1:0]       upper_clk_sel,
	input  wire logic             lower_run,
	input  wire logic             upper_timer_run_bit,
	input  wire logic             prescaler_run,
	input  wire logic             tap_t1,
	input  wire logic             tap_t4,
	input  wire logic             tap_t16,
	input  wire logic             tap_t256,
	input  wire logic             ext_clk_pin,
	input  wire logic             dbuf_en,
	input  wire logic             duty_wr,
	input  wire logic [CNT_W-1:0] duty_wdata,
	input  wire logic             period_wr,
	input  wire logic [CNT_W-1:0] period_wdata,
	input  wire logic             ffc_wr,
	input  wire logic [1:0]       ffc_field,
	input  wire logic             ff_toggle_en,
	input  wire logic             ff_toggle_src,
	input  wire logic             port7_direction_control,
	input  wire logic             port7_function_control,
	output logic      [1:0]       ffc_readback,
	output logic      [CNT_W-1:0] lower_up_counter,
	output logic      [CNT_W-1:0] upper_up_counter,
	output logic      [CNT_W-1:0] duty_register,
	output logic      [CNT_W-1:0] period_register,
	output logic      [CNT_W-1:0] duty_buffer,
	output logic                  lower_match,
	output logic                  upper_match,
	output logic                  output_flip_flop,
	output logic                  timer_output_pin,
	output logic                  timer_output_oe
);

	dtp_mode_t        mode;
	logic [CNT_W-1:0] lower_inc;
	logic [CNT_W-1:0] upper_inc;
	logic [CNT_W-1:0] pwm_ovf;
	logic             ext_sync1_r;
	logic             ext_sync2_r;
	logic             ext_prev_r;
	logic [1:0]       ext_arm_r;
	logic             ext_tick;
	logic             lower_tick;
	logic             upper_tick;
	logic             duty_hit;
	logic             period_hit;
	logic             ovf_hit;
	logic             lower_wrap;
	logic             upper_wrap;
	logic             upper_run_eff;
	logic             buf_load;
	logic             dbuf_active;
	logic             hw_toggle;
	logic             sw_toggle;
	logic             lower_match_nxt;
	logic             upper_match_nxt;

	assign mode = dtp_decode_mode(mode_field);

	// Pin clock is asynchronous; two stages before the edge detector
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ext_sync1_r <= 1'b0;
			ext_sync2_r <= 1'b0;
			ext_prev_r  <= 1'b0;
		end else begin
			ext_sync1_r <= ext_clk_pin;
			ext_sync2_r <= ext_sync1_r;
			ext_prev_r  <= ext_sync2_r;
		end
	end

	// A pin idling high looks like an edge while the stages fill after reset;
	// edges count only once the synchroniser has settled
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ext_arm_r <= 2'h0;
		end else if (ext_arm_r != 2'h3) begin
			ext_arm_r <= ext_arm_r + 2'h1;
		end
	end

	assign ext_tick = ext_sync2_r & ~ext_prev_r & (ext_arm_r == 2'h3);

	// Lower timer clock; the fastest tap is code 01
	always_comb begin
		lower_tick = 1'b0;
		case (lower_clk_sel)
			`DTP_LCLK_EXT: lower_tick = ext_tick;
			`DTP_LCLK_T1:  lower_tick = tap_t1 & prescaler_run;
			`DTP_LCLK_T4:  lower_tick = tap_t4 & prescaler_run;
			`DTP_LCLK_T16: lower_tick = tap_t16 & prescaler_run;
			default:       lower_tick = 1'b0;
		endcase
	end

	// PWM period exponent; code 00 falls back to the full 8-bit period
	always_comb begin
		pwm_ovf = `DTP_PWM_OVF_8;
		case (pwm_period_sel)
			`DTP_PWM_SEL_6: pwm_ovf = `DTP_PWM_OVF_6;
			`DTP_PWM_SEL_7: pwm_ovf = `DTP_PWM_OVF_7;
			`DTP_PWM_SEL_8: pwm_ovf = `DTP_PWM_OVF_8;
			default:        pwm_ovf = `DTP_PWM_OVF_8;
		endcase
	end

	// Compares look at the value the counter is about to reach
	assign lower_inc  = lower_up_counter + 1'b1;
	assign upper_inc  = upper_up_counter + 1'b1;
	assign duty_hit   = lower_run & lower_tick & (lower_inc == duty_register);
	assign period_hit = lower_run & lower_tick & (lower_inc == period_register);
	assign ovf_hit    = lower_run & lower_tick & (lower_inc == pwm_ovf);

	// Wrap choice per mode: period in pulse mode, 2^n-1 in PWM
	always_comb begin
		lower_wrap = 1'b0;
		case (mode)
			DTP_PPG:      lower_wrap = (lower_inc == period_register);
			DTP_PWM:      lower_wrap = (lower_inc == pwm_ovf);
			DTP_INTERVAL: lower_wrap = (lower_inc == duty_register);
			DTP_CASCADE:  lower_wrap = (lower_inc == duty_register);
			default:      lower_wrap = 1'b0;
		endcase
	end

	// Lower match feeds the upper clock in every mode except PWM
	always_comb begin
		upper_tick = 1'b0;
		case (upper_clk_sel)
			`DTP_UCLK_MATCH: upper_tick = (mode != DTP_PWM) & lower_match_nxt;
			`DTP_UCLK_T1:    upper_tick = tap_t1 & prescaler_run;
			`DTP_UCLK_T16:   upper_tick = tap_t16 & prescaler_run;
			`DTP_UCLK_T256:  upper_tick = tap_t256 & prescaler_run;
			default:         upper_tick = 1'b0;
		endcase
	end

	// In pulse mode the upper counter stays cleared, the lower does the work
	assign upper_run_eff = upper_timer_run_bit & (mode != DTP_PPG);
	assign upper_wrap    = (upper_inc == period_register);

	assign lower_match_nxt = (mode == DTP_PWM) ? ovf_hit :
		(mode == DTP_PPG) ? period_hit : duty_hit;
	assign upper_match_nxt = upper_run_eff & upper_tick & upper_wrap;

	dtp_counter #(
		.W(CNT_W)
	) u_lower (
		.clk_sys(clk_sys),
		.rst_n  (rst_n),
		.run    (lower_run),
		.tick   (lower_tick),
		.wrap   (lower_wrap),
		.count  (lower_up_counter)
	);

	dtp_counter #(
		.W(CNT_W)
	) u_upper (
		.clk_sys(clk_sys),
		.rst_n  (rst_n),
		.run    (upper_run_eff),
		.tick   (upper_tick),
		.wrap   (upper_wrap),
		.count  (upper_up_counter)
	);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lower_match <= 1'b0;
		end else begin
			lower_match <= lower_match_nxt;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			upper_match <= 1'b0;
		end else begin
			upper_match <= upper_match_nxt;
		end
	end

	// Buffer transfer point: period match or PWM overflow
	always_comb begin
		buf_load = 1'b0;
		case (mode)
			DTP_PPG: buf_load = dbuf_en & period_hit;
			DTP_PWM: buf_load = dbuf_en & ovf_hit;
			default: buf_load = 1'b0;
		endcase
	end

	// Buffering only applies in the two compare modes
	assign dbuf_active = dbuf_en & ((mode == DTP_PPG) | (mode == DTP_PWM));

	// Buffered writes only land in the buffer; a same-cycle load takes the old buffer
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			duty_buffer <= `DTP_RST_REG;
		end else if (duty_wr) begin
			duty_buffer <= duty_wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			duty_register <= `DTP_RST_REG;
		end else if (buf_load) begin
			duty_register <= duty_buffer;
		end else if (duty_wr && !dbuf_active) begin
			duty_register <= duty_wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			period_register <= `DTP_RST_REG;
		end else if (period_wr) begin
			period_register <= period_wdata;
		end
	end

	// Hardware toggle sources; duty below period keeps the two hits apart
	always_comb begin
		hw_toggle = 1'b0;
		case (mode)
			DTP_PPG: hw_toggle = duty_hit ^ period_hit;
			DTP_PWM: hw_toggle = duty_hit ^ ovf_hit;
			default: hw_toggle = ff_toggle_src ? upper_match_nxt : duty_hit;
		endcase
		hw_toggle = hw_toggle & ff_toggle_en;
	end

	assign sw_toggle = ffc_wr & (ffc_field == `DTP_FFC_TOGGLE);

	// Software set or clear beats a hardware toggle in the same cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			output_flip_flop <= `DTP_RST_FF;
		end else if (ffc_wr && ffc_field == `DTP_FFC_SET) begin
			output_flip_flop <= 1'b1;
		end else if (ffc_wr && ffc_field == `DTP_FFC_CLEAR) begin
			output_flip_flop <= 1'b0;
		end else if (hw_toggle ^ sw_toggle) begin
			output_flip_flop <= ~output_flip_flop;
		end
	end

	assign ffc_readback = `DTP_FFC_READBACK;

	// Pin follows the shared flip-flop; the upper timer has no pin of its own
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			timer_output_pin <= `DTP_RST_FF;
		end else begin
			timer_output_pin <= output_flip_flop;
		end
	end

	// Enable is registered like the pin so both change on the same edge
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			timer_output_oe <= 1'b0;
		end else begin
			timer_output_oe <= port7_direction_control & port7_function_control;
		end
	end

endmodule : dtp_top

// ---- verif/dtp_top_checker.sv ----
// Concurrent checks on the timer pair ports: wraps, toggles, pin, control field.
// Assumes tap_t1 with lower_clk_sel 01 is the lower clock whenever ticks are checked.
`timescale 1ns/1ps
module dtp_top_checker
	import dtp_pkg::*;
#(
	parameter int CNT_W = 8
) (
	input wire logic             clk_sys,
	input wire logic             rst_n,
	input wire logic [1:0]       mode_field,
	input wire logic [1:0]       pwm_period_sel,
	input wire logic [1:0]       lower_clk_sel,
	input wire logic             lower_run,
	input wire logic             prescaler_run,
	input wire logic             tap_t1,
	input wire logic             dbuf_en,
	input wire logic             ffc_wr,
	input wire logic [1:0]       ffc_field,
	input wire logic             ff_toggle_en,
	input wire logic [1:0]       ffc_readback,
	input wire logic [CNT_W-1:0] lower_up_counter,
	input wire logic [CNT_W-1:0] upper_up_counter,
	input wire logic [CNT_W-1:0] duty_register,
	input wire logic [CNT_W-1:0] period_register,
	input wire logic [CNT_W-1:0] duty_buffer,
	input wire logic             output_flip_flop,
	input wire logic             timer_output_pin
);
	logic [CNT_W-1:0] nxt;
	logic [CNT_W-1:0] top;
	assign nxt = lower_up_counter + 1'b1;
	assign top = (mode_field == 2'h2) ? period_register :
		(pwm_period_sel == 2'h1) ? CNT_W'(8'h3F) :
		(pwm_period_sel == 2'h2) ? CNT_W'(8'h7F) : CNT_W'(8'hFF);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence tick_s;
		mode_field[1] && lower_run && prescaler_run && tap_t1 && lower_clk_sel == 2'h1;
	endsequence
	sequence wrap_s;
		tick_s ##0 nxt == top;
	endsequence
	sequence hw_ok_s;
		ff_toggle_en && !ffc_wr;
	endsequence
	ppg_restart_a: assert property (wrap_s ##0 mode_field == 2'h2 |=> lower_up_counter == '0)
		else $error("pulse counter did not restart");
	pwm_wrap_a: assert property (wrap_s ##0 mode_field == 2'h3 |=> lower_up_counter == '0)
		else $error("pwm counter did not wrap");
	duty_toggle_a: assert property (tick_s ##0 nxt == duty_register && nxt != top ##0 hw_ok_s
		|=> output_flip_flop != $past(output_flip_flop))
		else $error("no toggle on duty hit");
	top_toggle_a: assert property (wrap_s ##0 nxt != duty_register ##0 hw_ok_s
		|=> output_flip_flop != $past(output_flip_flop))
		else $error("no toggle on top hit");
	dbuf_load_a: assert property (wrap_s ##0 dbuf_en |=> duty_register == $past(duty_buffer))
		else $error("buffered duty not loaded");
	pin_follow_a: assert property (1'b1 |=> timer_output_pin == $past(output_flip_flop))
		else $error("pin does not follow flip-flop");
	ffc_set_a: assert property (ffc_wr && ffc_field == 2'h1 |=> output_flip_flop)
		else $error("set code failed");
	ffc_clear_a: assert property (ffc_wr && ffc_field == 2'h2 |=> !output_flip_flop)
		else $error("clear code failed");
	ffc_toggle_a: assert property (ffc_wr && ffc_field == 2'h0 && !lower_run
		|=> output_flip_flop != $past(output_flip_flop))
		else $error("toggle code failed");
	ffc_none_a: assert property (ffc_wr && ffc_field == 2'h3 && !lower_run
		|=> $stable(output_flip_flop))
		else $error("no-op code changed flip-flop");
	ffc_read_a: assert property (ffc_readback == 2'h3)
		else $error("control field readback wrong");
	stop_clear_a: assert property (!lower_run |=> lower_up_counter == '0)
		else $error("stopped counter not clear");
	upper_hold_a: assert property (mode_field == 2'h2 [*2] |-> upper_up_counter == '0)
		else $error("upper counter ran in pulse mode");
endmodule : dtp_top_checker

bind dtp_top dtp_top_checker #(.CNT_W(CNT_W)) chk (.*);

// ---- verif/dual_timer_ppg_pwm_modes_bench.sv ----
// Self-checking bench for the timer pair: control codes, pulse and PWM runs.
// Assumes tap_t1 pulses every cycle, so each clock is one lower-counter tick.
`timescale 1ns/1ps
module dual_timer_ppg_pwm_modes_bench;
	import dtp_pkg::*;
	logic       clk_sys, rst_n, lower_run, upper_timer_run_bit, prescaler_run, tap_t1;
	logic       tap_t4, tap_t16, tap_t256, ext_clk_pin, dbuf_en, duty_wr, period_wr, ffc_wr;
	logic       ff_toggle_en, ff_toggle_src, port7_direction_control, port7_function_control;
	logic       lower_match, upper_match, output_flip_flop, timer_output_pin, timer_output_oe;
	logic [1:0] mode_field, pwm_period_sel, lower_clk_sel, upper_clk_sel, ffc_field, ffc_readback;
	logic [7:0] duty_wdata, period_wdata, lower_up_counter, upper_up_counter;
	logic [7:0] duty_register, period_register, duty_buffer, mcnt, mduty, mbuf;
	logic       mff, mpin, mlm;
	int         errors, checked;
	dtp_top uut (.*);
	initial begin
		clk_sys = 0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic final_report;
		$display("checked=%0d errors=%0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report
	task automatic ffcw(input logic [1:0] f);
		ffc_field = f;
		ffc_wr = 1;
		@(negedge clk_sys);
		ffc_wr = 0;
		@(negedge clk_sys);
	endtask : ffcw
	// Stop, load registers unbuffered, preset flip-flop, then start counting
	task automatic start(input logic [1:0] m, s, input logic [7:0] per, d,
		input logic [1:0] f, input logic db);
		lower_run = 0;
		dbuf_en = 0;
		mode_field = m;
		pwm_period_sel = s;
		period_wr = 1;
		period_wdata = per;
		duty_wr = 1;
		duty_wdata = d;
		@(negedge clk_sys);
		period_wr = 0;
		duty_wr = 0;
		chk(lower_up_counter, 8'h00);
		ffcw(f);
		dbuf_en = db;
		lower_run = 1;
		mcnt = 8'h00;
		mff = (f == 2'h1);
		mpin = mff;
		mduty = d;
		mbuf = d;
	endtask : start
	// Reference walk: wrap at top, toggle on duty hit and on wrap
	task automatic run(input logic [7:0] top, input int n, wr_at, input logic [7:0] wv);
		logic [7:0] nx;
		for (int i = 0; i < n; i++) begin
			duty_wr = (i == wr_at);
			duty_wdata = wv;
			@(posedge clk_sys);
			nx = mcnt + 8'h01;
			mpin = mff;
			mff = mff ^ (nx == top) ^ (nx == mduty);
			mlm = (nx == top);
			mcnt = (nx == top) ? 8'h00 : nx;
			if (nx == top && dbuf_en) mduty = mbuf;
			if (duty_wr) begin
				mbuf = wv;
				if (!dbuf_en) mduty = wv;
			end
			@(negedge clk_sys);
			chk(lower_up_counter, mcnt);
			chk(output_flip_flop, mff);
			chk(timer_output_pin, mpin);
			chk(duty_register, mduty);
			chk(duty_buffer, mbuf);
			chk(lower_match, mlm);
		end
	endtask : run
	initial begin
		logic [1:0] codes [5];
		logic       exps [5];
		logic [7:0] top;
		codes = '{2'h1, 2'h0, 2'h3, 2'h0, 2'h2};
		exps = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
		errors = 0;
		checked = 0;
		{rst_n, lower_run, dbuf_en, duty_wr, period_wr, ffc_wr, tap_t4, tap_t16} = '0;
		{tap_t256, ext_clk_pin, ff_toggle_src, mode_field, pwm_period_sel, ffc_field} = '0;
		{duty_wdata, period_wdata} = '0;
		{tap_t1, prescaler_run, ff_toggle_en, upper_timer_run_bit} = 4'hF;
		{port7_direction_control, port7_function_control} = 2'h3;
		lower_clk_sel = 2'h1;
		upper_clk_sel = 2'h1;
		repeat (3) @(negedge clk_sys);
		rst_n = 1;
		chk(ffc_readback, 8'h03);
		for (int i = 0; i < 5; i++) begin
			ffcw(codes[i]);
			chk(output_flip_flop, exps[i]);
		end
		chk(timer_output_oe, 8'h01);
		start(2'h2, 2'h0, 8'h04, 8'h01, 2'h1, 1'b0);
		run(8'h04, 16, 6, 8'h02);
		start(2'h2, 2'h0, 8'h50, 8'h14, 2'h2, 1'b1);
		run(8'h50, 200, 30, 8'h28);
		chk(upper_up_counter, 8'h00);
		for (int s = 1; s < 4; s++) begin
			top = 8'((1 << (s + 5)) - 1);
			start(2'h3, 2'(s), 8'h00, 8'h10, 2'h2, 1'b1);
			run(top, 2 * top + 10, 20, 8'h30);
		end
		// PWM leaves the upper timer free, but never clocked by the lower match
		upper_timer_run_bit = 0;
		upper_clk_sel = 2'h0;
		period_wr = 1;
		period_wdata = 8'h05;
		@(negedge clk_sys);
		period_wr = 0;
		upper_timer_run_bit = 1;
		repeat (260) @(negedge clk_sys);
		chk(upper_up_counter, 8'h00);
		upper_clk_sel = 2'h1;
		for (int k = 1; k < 11; k++) begin
			@(negedge clk_sys);
			chk(upper_up_counter, 8'(k % 5));
			chk(upper_match, k % 5 == 0);
		end
		port7_function_control = 0;
		@(negedge clk_sys);
		chk(timer_output_oe, 8'h00);
		final_report();
	end
endmodule : dual_timer_ppg_pwm_modes_bench
